// ---- include/cetr_defs.vh ----
// constants shared by the command error table reader files
`ifndef CETR_DEFS_VH
`define CETR_DEFS_VH

// ---------------------------------------------------------------
// block codes and limits
// ---------------------------------------------------------------
`define CETR_TYPE_CODE      16'h26DE
`define CETR_DONE_FLAG      16'h0000
`define CETR_TABLE_SIZE     10'h3E8
`define CETR_LAST_INDEX     10'h3E7
`define CETR_MAX_COUNT      6'h3C
`define CETR_MIN_COUNT      6'h01
`define CETR_NEXT_ID_RESET  16'h0000

// ---------------------------------------------------------------
// word positions inside the request and response blocks
// ---------------------------------------------------------------
`define CETR_REQ_TYPE_W     6'h00
`define CETR_REQ_COUNT_W    6'h01
`define CETR_REQ_START_W    6'h02
`define CETR_RSP_COUNT_W    6'h02
`define CETR_RSP_START_W    6'h03
`define CETR_RSP_DATA_W     6'h04

// ---------------------------------------------------------------
// host port map (word addresses)
// ---------------------------------------------------------------
`define CETR_ADDR_BLOCK_HI  8'h3F
`define CETR_ADDR_CTRL      8'h40
`define CETR_ADDR_STATUS    8'h41
`define CETR_ADDR_NEXT_ID   8'h42

// control and status field positions
`define CETR_CTRL_LAYOUT    0
`define CETR_CTRL_START     1
`define CETR_STAT_BUSY      0
`define CETR_STAT_DONE      1
`define CETR_STAT_INVALID   2
`define CETR_STAT_INIT      3

`endif

// ---- hw/cetr_error_ram.v ----
// per-command last-error storage with a clearing sweep after reset
`timescale 1ns/1ps
`include "cetr_defs.vh"

module cetr_error_ram
(
	input  wire        core_clk_i,  // system clock
	input  wire        srst_i,      // synchronous reset, active high
	input  wire        wr_en_i,     // record an error for one command
	input  wire [9:0]  wr_idx_i,    // command index being recorded
	input  wire [15:0] wr_data_i,   // error value
	input  wire [9:0]  rd_idx_i,    // command index to read
	output reg  [15:0] rd_data_o,   // error value, one cycle after rd_idx_i
	output reg         init_o       // high while the table is being cleared
);

	reg [15:0] table_mem [0:999];
	reg [9:0]  sweep_idx;

	// ---------------------------------------------------------------
	// clearing sweep
	// ---------------------------------------------------------------
	// entries are zeroed once after reset so reads never return junk;
	// a live write that arrives while the sweep runs is dropped, since the sweep owns the port
	always @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			sweep_idx <= 10'h000;
			init_o    <= 1'b1;
		end
		else if (init_o)
		begin
			if (sweep_idx == `CETR_LAST_INDEX)
				init_o <= 1'b0;
			sweep_idx <= sweep_idx + 10'h001;
		end
	end

	// single write port: the sweep owns it until the table is clean
	always @(posedge core_clk_i)
	begin
		if (init_o)
			table_mem[sweep_idx] <= 16'h0000;
		else if (wr_en_i && (wr_idx_i < `CETR_TABLE_SIZE))
			table_mem[wr_idx_i] <= wr_data_i;
	end

	// registered read port
	always @(posedge core_clk_i)
	begin
		rd_data_o <= table_mem[rd_idx_i];
	end

endmodule // cetr_error_ram

// ---- hw/cetr_reader.v ----
// command error table reader: answers table slice requests from the host
//
// Overview of operation
// - a valid request yields a response block holding the table slice.
// - the error table holds one entry for each of 1000 commands.
// - block-transfer layout carries type code 9950 in word zero.
// - block-transfer layout carries next wanted block id in word one.
// - word two reports entries carried, always one to sixty.
// - word three reports the start index of the first returned entry.
// - only the reported count of error words is valid; rest is zero.
// - side-connect layout: zero flag, type code, count, start, errors.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "cetr_defs.vh"

module cetr_reader
(
	input  wire        core_clk_i,  // system clock, 200 MHz
	input  wire        srst_i,      // synchronous reset, active high
	input  wire [7:0]  host_addr_i, // host word address
	input  wire [15:0] host_wdata_i,// host write data
	input  wire        host_wr_i,   // host write strobe
	input  wire        host_rd_i,   // host read strobe
	output reg  [15:0] host_rdata_o,// read data, cycle after the strobe
	input  wire        err_wr_i,    // command engine records an error
	input  wire [9:0]  err_idx_i,   // command index of that error
	input  wire [15:0] err_code_i,  // error value
	output reg         busy_o,      // response block being built
	output reg         done_o,      // response block ready
	output reg         invalid_o    // last request was refused
);

	// ---------------------------------------------------------------
	// state and storage
	// ---------------------------------------------------------------
	localparam ST_IDLE  = 2'b00;
	localparam ST_CHECK = 2'b01;
	localparam ST_ADDR  = 2'b10;
	localparam ST_DATA  = 2'b11;

	reg [15:0] req_mem [0:63];
	reg [15:0] rsp_mem [0:63];
	reg [1:0]  state;
	reg        layout;      // 0 block-transfer, 1 side-connect
	reg [15:0] next_id;     // next block the module asks for
	reg [9:0]  rd_idx;
	reg [5:0]  fill_cnt;
	reg [5:0]  eff_cnt;
	reg [9:0]  first_idx;
	integer    k;

	wire [15:0] ram_data;
	wire        ram_init;

	// register map decode, shared by the write and read paths
	function is_block;
		input [7:0] a;
		begin
			is_block = (a <= `CETR_ADDR_BLOCK_HI);
		end
	endfunction

	// ---------------------------------------------------------------
	// request validity
	// ---------------------------------------------------------------
	// only words zero to two are looked at; the spare area is never read
	wire [15:0] req_type  = req_mem[`CETR_REQ_TYPE_W];
	wire [15:0] req_count = req_mem[`CETR_REQ_COUNT_W];
	wire [15:0] req_start = req_mem[`CETR_REQ_START_W];

	wire type_ok  = (req_type == `CETR_TYPE_CODE);
	wire count_ok = (req_count >= {10'h000, `CETR_MIN_COUNT}) &&
	                (req_count <= {10'h000, `CETR_MAX_COUNT});
	wire start_ok = (req_start < {6'h00, `CETR_TABLE_SIZE});
	wire req_ok   = type_ok && count_ok && start_ok;

	// entries left before the table end; a slice is cut short there
	wire [9:0] room    = `CETR_TABLE_SIZE - req_start[9:0];
	wire [5:0] cut_cnt = (room < {4'h0, req_count[5:0]}) ? room[5:0]
	                                                      : req_count[5:0];

	// ---------------------------------------------------------------
	// error table
	// ---------------------------------------------------------------
	cetr_error_ram u_table
	(
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.wr_en_i    (err_wr_i),
		.wr_idx_i   (err_idx_i),
		.wr_data_i  (err_code_i),
		.rd_idx_i   (rd_idx),
		.rd_data_o  (ram_data),
		.init_o     (ram_init)
	);

	// ---------------------------------------------------------------
	// host writes: request block and control words
	// ---------------------------------------------------------------
	always @(posedge core_clk_i)
	begin
		if (host_wr_i && is_block(host_addr_i))
			req_mem[host_addr_i[5:0]] <= host_wdata_i;
	end

	always @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			layout  <= 1'b0;
			next_id <= `CETR_NEXT_ID_RESET;
		end
		else if (host_wr_i)
		begin
			if (host_addr_i == `CETR_ADDR_CTRL)
				layout <= host_wdata_i[`CETR_CTRL_LAYOUT];
			if (host_addr_i == `CETR_ADDR_NEXT_ID)
				next_id <= host_wdata_i;
		end
	end

	// a start is honoured only when idle and the table is clean
	wire start_req = host_wr_i && (host_addr_i == `CETR_ADDR_CTRL) &&
	                 host_wdata_i[`CETR_CTRL_START];
	wire start_go  = start_req && (state == ST_IDLE) && !ram_init;

	// ---------------------------------------------------------------
	// response builder
	// ---------------------------------------------------------------
	// one table word every two cycles; slow but keeps a single read port
	always @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			state     <= ST_IDLE;
			busy_o    <= 1'b0;
			done_o    <= 1'b0;
			invalid_o <= 1'b0;
			rd_idx    <= 10'h000;
			fill_cnt  <= 6'h00;
			eff_cnt   <= 6'h00;
			first_idx <= 10'h000;
		end
		else
		begin
			case (state)
			ST_IDLE:
			begin
				if (start_go)
				begin
					state     <= ST_CHECK;
					busy_o    <= 1'b1;
					done_o    <= 1'b0;
					invalid_o <= 1'b0;
				end
			end
			ST_CHECK:
			begin
				if (req_ok)
				begin
					state     <= ST_ADDR;
					rd_idx    <= req_start[9:0];
					first_idx <= req_start[9:0];
					eff_cnt   <= cut_cnt;
					fill_cnt  <= 6'h00;
				end
				else
				begin
					state     <= ST_IDLE;
					busy_o    <= 1'b0;
					done_o    <= 1'b1;
					invalid_o <= 1'b1;
				end
			end
			ST_ADDR:
				state <= ST_DATA;
			ST_DATA:
			begin
				fill_cnt <= fill_cnt + 6'h01;
				rd_idx   <= rd_idx + 10'h001;
				if (fill_cnt + 6'h01 == eff_cnt)
				begin
					state  <= ST_IDLE;
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end
				else
					state <= ST_ADDR;
			end
			default:
				state <= ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// response block contents
	// ---------------------------------------------------------------
	// the whole block is zeroed at start so unused error words and a
	// refused request carry no stale data
	always @(posedge core_clk_i)
	begin
		if (state == ST_IDLE && start_go)
		begin
			for (k = 0; k < 64; k = k + 1)
				rsp_mem[k] <= 16'h0000;
		end
		else if (state == ST_CHECK && req_ok)
		begin
			if (layout)
			begin
				rsp_mem[0] <= `CETR_DONE_FLAG;
				rsp_mem[1] <= `CETR_TYPE_CODE;
			end
			else
			begin
				rsp_mem[0] <= `CETR_TYPE_CODE;
				rsp_mem[1] <= next_id;
			end
			rsp_mem[`CETR_RSP_COUNT_W] <= {10'h000, cut_cnt};
			rsp_mem[`CETR_RSP_START_W] <= {6'h00, req_start[9:0]};
		end
		else if (state == ST_DATA)
			rsp_mem[`CETR_RSP_DATA_W + fill_cnt] <= ram_data;
	end

	// ---------------------------------------------------------------
	// host reads
	// ---------------------------------------------------------------
	always @(posedge core_clk_i)
	begin
		if (srst_i)
			host_rdata_o <= 16'h0000;
		else if (host_rd_i)
		begin
			if (is_block(host_addr_i))
				host_rdata_o <= rsp_mem[host_addr_i[5:0]];
			else if (host_addr_i == `CETR_ADDR_CTRL)
				host_rdata_o <= {15'h0000, layout};
			else if (host_addr_i == `CETR_ADDR_STATUS)
				host_rdata_o <= {12'h000, ram_init, invalid_o, done_o, busy_o};
			else if (host_addr_i == `CETR_ADDR_NEXT_ID)
				host_rdata_o <= next_id;
			else
				host_rdata_o <= 16'h0000;
		end
		else
			host_rdata_o <= 16'h0000;
	end

endmodule // cetr_reader

// ---- verif/cetr_reader_props.sv ----
// checker for the reader's host port and status flags
`timescale 1ns/1ps
`include "cetr_defs.vh"
// ------------------------------
// reader checker
// ------------------------------
module cetr_reader_props
(
	input wire        core_clk_i,   // clock
	input wire        srst_i,       // reset
	input wire [7:0]  host_addr_i,  // address
	input wire [15:0] host_wdata_i, // write data
	input wire        host_wr_i,    // write strobe
	input wire        host_rd_i,    // read strobe
	input wire [15:0] host_rdata_o, // read data
	input wire        busy_o,       // building
	input wire        done_o,       // finished
	input wire        invalid_o     // refused
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	// start bit written to control
	wire ctrl_start = host_wr_i && host_addr_i == `CETR_ADDR_CTRL && host_wdata_i[1];
	a_busy_start: assert property ($rose(busy_o) |-> $past(ctrl_start))
		else $error("busy without start");
	a_fill_bound: assert property ($rose(busy_o) |-> ##[1:122] !busy_o)
		else $error("fill too long");
	// a one-cycle build can only be a refusal
	a_refuse_fast: assert property ($fell(busy_o) |-> invalid_o == !$past(busy_o, 2))
		else $error("refusal timing wrong");
	a_done_ends: assert property ($rose(done_o) |-> $fell(busy_o))
		else $error("done not at end of build");
	a_done_kept: assert property ($fell(done_o) |-> $past(ctrl_start))
		else $error("done dropped without start");
	a_flag_excl: assert property (invalid_o |-> done_o && !busy_o)
		else $error("invalid flag alone");
	a_read_once: assert property (!$past(host_rd_i) |-> host_rdata_o == 16'h0000)
		else $error("read data outside its cycle");
	a_stat_mirror: assert property ($past(host_rd_i) && $past(host_addr_i) == `CETR_ADDR_STATUS
		|-> host_rdata_o[2:0] == {$past(invalid_o), $past(done_o), $past(busy_o)})
		else $error("status differs from flags");
	c_valid: cover property ($fell(busy_o) && !invalid_o);
	c_refused: cover property ($rose(invalid_o));
	c_stat: cover property ($past(host_rd_i) && done_o);
endmodule // cetr_reader_props

// ---- verif/cetr_host_model.sv ----
// host controller model: register cycles and request blocks
`timescale 1ns/1ps
`include "cetr_defs.vh"
// ------------------------------
// host model
// ------------------------------
module cetr_host_model
(
	input  wire        core_clk_i,   // clock
	output reg  [7:0]  host_addr_o,  // address
	output reg  [15:0] host_wdata_o, // write data
	output reg         host_wr_o,    // write strobe
	output reg         host_rd_o,    // read strobe
	input  wire [15:0] host_rdata_i  // read data
);
	initial
	begin
		host_addr_o = 8'h00;
		host_wdata_o = 16'h0000;
		host_wr_o = 1'b0;
		host_rd_o = 1'b0;
	end
	// idle data is inverted so a stale word never looks valid
	task wr(input [7:0] a, input [15:0] d);
	begin
		@(posedge core_clk_i);
		host_addr_o <= a;
		host_wdata_o <= d;
		host_wr_o <= 1'b1;
		@(posedge core_clk_i);
		host_wr_o <= 1'b0;
		host_wdata_o <= ~d;
	end
	endtask
	// answer stands only in the cycle after the strobe
	task rd(input [7:0] a, output [15:0] d);
	begin
		@(posedge core_clk_i);
		host_addr_o <= a;
		host_rd_o <= 1'b1;
		@(posedge core_clk_i);
		host_rd_o <= 1'b0;
		#1 d = host_rdata_i;
	end
	endtask
	// request block plus a noisy spare word, then start
	task req(input [15:0] t, c, s, input l);
	begin
		wr(8'h00, t);
		wr(8'h01, c);
		wr(8'h02, s);
		wr(8'h03, 16'hFFFF);
		wr(`CETR_ADDR_CTRL, {14'h0000, 1'b1, l});
	end
	endtask
endmodule // cetr_host_model

// ---- verif/testbench.sv ----
// bench top: requests table slices and checks every response word
`timescale 1ns/1ps
`include "cetr_defs.vh"
// ------------------------------
// bench top
// ------------------------------
module testbench;
	reg         core_clk_i = 1'b0;
	reg         srst_i = 1'b1;
	reg         err_wr_i = 1'b0;
	reg  [9:0]  err_idx_i = 10'h000;
	reg  [15:0] err_code_i = 16'h0000;
	wire [7:0]  host_addr_i;
	wire [15:0] host_wdata_i, host_rdata_o;
	wire        host_wr_i, host_rd_i, busy_o, done_o, invalid_o;
	reg  [15:0] nid = 16'h0000; // next block id set by software
	reg  [15:0] v;
	integer     err_total = 0;
	integer     compares = 0;
	integer     i;
	always #2.5 core_clk_i = ~core_clk_i;
	cetr_reader i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .host_addr_i(host_addr_i),
		.host_wdata_i(host_wdata_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
		.host_rdata_o(host_rdata_o), .err_wr_i(err_wr_i), .err_idx_i(err_idx_i),
		.err_code_i(err_code_i), .busy_o(busy_o), .done_o(done_o), .invalid_o(invalid_o));
	cetr_host_model i_host (.core_clk_i(core_clk_i), .host_addr_o(host_addr_i),
		.host_wdata_o(host_wdata_i), .host_wr_o(host_wr_i), .host_rd_o(host_rd_i),
		.host_rdata_i(host_rdata_o));
	task cmp(input [15:0] got, exp);
	begin
		compares = compares + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task complete_run;
	begin
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	// index 5 was overwritten, so it shows the latest value
	function [15:0] ev(input integer p);
		ev = (p == 5) ? 16'h5555 : (16'hA000 | p[15:0]);
	endfunction
	task run(input [15:0] t, c, s, input l);
		integer n, k;
		reg ok;
		reg [15:0] e;
	begin
		ok = t == `CETR_TYPE_CODE && c >= `CETR_MIN_COUNT && c <= `CETR_MAX_COUNT
			&& s < `CETR_TABLE_SIZE;
		n = (c > `CETR_TABLE_SIZE - s) ? `CETR_TABLE_SIZE - s : c;
		i_host.req(t, c, s, l);
		// status two edges after the start: still building, or already refused
		i_host.rd(`CETR_ADDR_STATUS, v);
		cmp(v, ok ? 16'h0001 : 16'h0006);
		k = 0;
		do
		begin
			@(posedge core_clk_i);
			#1 k = k + 1;
		end
		while (done_o !== 1'b1 && k < 200);
		// the flag pins themselves, not only their status mirror
		cmp({13'h0000, invalid_o, done_o, busy_o}, ok ? 16'h0002 : 16'h0006);
		i_host.rd(`CETR_ADDR_STATUS, v);
		cmp(v, ok ? 16'h0002 : 16'h0006);
		for (k = 0; k < 64; k = k + 1)
		begin
			i_host.rd(k[7:0], v);
			e = !ok ? 16'h0000 : k == 0 ? (l ? 16'h0000 : `CETR_TYPE_CODE)
				: k == 1 ? (l ? `CETR_TYPE_CODE : nid) : k == 2 ? n[15:0]
				: k == 3 ? s : k - 4 < n ? ev(s + k - 4) : 16'h0000;
			cmp(v, e);
		end
		// layout choice must read back as written with the start
		i_host.rd(`CETR_ADDR_CTRL, v);
		cmp(v, {15'h0000, l});
	end
	endtask
	initial
	begin
		repeat (20) @(posedge core_clk_i);
		srst_i <= 1'b0;
		i_host.rd(`CETR_ADDR_STATUS, v);
		cmp(v, 16'h0008);
		i = 0;
		// clearing sweep takes about a thousand cycles
		do
		begin
			i_host.rd(`CETR_ADDR_STATUS, v);
			i = i + 1;
		end
		while (v !== 16'h0000 && i < 1200);
		cmp(v, 16'h0000);
		i_host.rd(`CETR_ADDR_NEXT_ID, v);
		cmp(v, 16'h0000);
		nid = 16'h1234;
		i_host.wr(`CETR_ADDR_NEXT_ID, nid);
		i_host.rd(`CETR_ADDR_NEXT_ID, v);
		cmp(v, nid);
		i_host.rd(8'h50, v);
		cmp(v, 16'h0000);
		// fill all 1000 entries, then overwrite entry 5
		for (i = 0; i <= 1000; i = i + 1)
		begin
			@(posedge core_clk_i);
			err_wr_i <= 1'b1;
			err_idx_i <= (i == 1000) ? 10'h005 : i[9:0];
			err_code_i <= (i == 1000) ? 16'h5555 : 16'hA000 | i[15:0];
		end
		@(posedge core_clk_i);
		err_wr_i <= 1'b0;
		run(`CETR_TYPE_CODE, 16'h003C, 16'h0000, 1'b0);
		run(`CETR_TYPE_CODE, 16'h000A, 16'h03E3, 1'b1);
		run(`CETR_TYPE_CODE, 16'h0001, 16'h03E7, 1'b0);
		run(`CETR_TYPE_CODE, 16'h0000, 16'h0003, 1'b1);
		run(`CETR_TYPE_CODE, 16'h003D, 16'h0003, 1'b0);
		run(`CETR_TYPE_CODE, 16'h0004, 16'h03E8, 1'b0);
		run(16'h26DF, 16'h0004, 16'h0003, 1'b1);
		complete_run;
	end
	// watchdog: the run needs about 3200 cycles
	initial
	begin
		#100000;
		err_total = err_total + 1;
		complete_run;
	end
endmodule // testbench
bind cetr_reader cetr_reader_props i_props (.core_clk_i(core_clk_i), .srst_i(srst_i),
	.host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_wr_i(host_wr_i),
	.host_rd_i(host_rd_i), .host_rdata_o(host_rdata_o), .busy_o(busy_o), .done_o(done_o),
	.invalid_o(invalid_o));
